// ---- design/tcdr_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module tcdr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } tcdr_fifo_state_t;
  tcdr_fifo_state_t q, d;
  logic push, pop;

  assign in_ready_o = (q.cnt < (PW + 1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else if (en_i) begin
      q <= d;
    end
  end

  a_fifo_bound: assert property (@(posedge clk_i) disable iff (!nrst_i)
    q.cnt <= (PW + 1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

module tcdr_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  output logic [7:0] io_rdata_o,
  input wire logic nmi_i,
  input wire logic ch0_request_n_i,
  input wire logic ch1_request_n_i,
  output logic xfer_valid_o,
  input wire logic xfer_ready_i,
  output logic xfer_ch_o,
  output logic xfer_src_io_o,
  output logic xfer_dst_io_o,
  output logic xfer_last_o,
  output logic [19:0] xfer_src_addr_o,
  output logic [19:0] xfer_dst_addr_o,
  output logic bus_hold_o,
  output logic ch0_irq_o,
  output logic ch1_irq_o,
  output logic [1:0] mem_wait_o,
  output logic [1:0] io_wait_o
);
  typedef struct packed {
    logic [19:0] ch0_source_address;
    logic [19:0] ch0_destination_address;
    logic [19:0] ch1_memory_address;
    logic [15:0] ch1_io_address;
    logic [15:0] ch0_byte_count;
    logic [15:0] ch1_byte_count;
    logic de0;
    logic de1;
    logic ie0;
    logic ie1;
    logic main_enable;
    logic [7:0] mode;
    logic [7:0] ctl;
    logic [2:0] s0;
    logic [2:0] s1;
    logic lv0;
    logic lv1;
    logic pend0;
    logic pend1;
    tcdr_pkg::tcdr_state_t st;
    logic ch;
    logic [7:0] rdata;
    logic irq0;
    logic irq1;
    logic hold;
    logic ov;
    logic [tcdr_pkg::DESC_W-1:0] od;
  } tcdr_regs_t;
  tcdr_regs_t q, d;

  logic push, f_ready, f_valid, f_pop;
  logic [tcdr_pkg::DESC_W-1:0] desc, f_data;
  logic act0, act1, m2m0, req0, req1, sel_act, last;
  logic [1:0] dm, sm;
  logic [7:0] a;
  logic [7:0] w;

  function automatic logic [19:0] step(input logic [19:0] v, input logic [1:0] m);
    case (m)
      tcdr_pkg::AM_INC: step = v + 20'h00001;
      tcdr_pkg::AM_DEC: step = v - 20'h00001;
      default: step = v;
    endcase
  endfunction

  assign a = io_addr_i;
  assign w = io_wdata_i;
  assign dm = q.mode[tcdr_pkg::MD_DST_LO +: 2];
  assign sm = q.mode[tcdr_pkg::MD_SRC_LO +: 2];
  assign act0 = q.de0 & q.main_enable;
  assign act1 = q.de1 & q.main_enable;
  // Reserved combinations are not trapped; they run as their fields decode
  assign m2m0 = (dm != tcdr_pkg::AM_IO) && (sm != tcdr_pkg::AM_IO);
  assign req0 = q.ctl[tcdr_pkg::CT_SENSE0] ? q.pend0 : !q.lv0;
  assign req1 = q.ctl[tcdr_pkg::CT_SENSE1] ? q.pend1 : !q.lv1;
  assign sel_act = q.ch ? act1 : act0;
  assign push = (q.st == tcdr_pkg::ST_MOVE) && sel_act && f_ready;
  assign last = q.ch ? (q.ch1_byte_count == 16'h0001) : (q.ch0_byte_count == 16'h0001);
  assign f_pop = !q.ov || xfer_ready_i;

  always_comb begin
    if (q.ch) begin
      // Channel 1 I/O address never steps
      if (q.ctl[tcdr_pkg::CT_DIR]) begin
        desc = {1'b1, 1'b1, 1'b0, last, 4'h0, q.ch1_io_address, q.ch1_memory_address};
      end else begin
        desc = {1'b1, 1'b0, 1'b1, last, q.ch1_memory_address, 4'h0, q.ch1_io_address};
      end
    end else begin
      desc = {1'b0, sm == tcdr_pkg::AM_IO, dm == tcdr_pkg::AM_IO, last, q.ch0_source_address, q.ch0_destination_address};
    end
  end

  tcdr_fifo #(.WIDTH(tcdr_pkg::DESC_W), .DEPTH(tcdr_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .in_valid_i(push),
    .in_ready_o(f_ready),
    .in_data_i(desc),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );

  always_comb begin
    d = q;
    // Pin requests: change accepted once second and third stages agree
    d.s0 = {q.s0[1:0], ch0_request_n_i};
    d.s1 = {q.s1[1:0], ch1_request_n_i};
    if (q.s0[1] == q.s0[2]) begin
      d.lv0 = q.s0[2];
    end
    if (q.s1[1] == q.s1[2]) begin
      d.lv1 = q.s1[2];
    end
    // Engine: a byte takes one cycle; the FIFO stalls it when full
    unique case (q.st)
      tcdr_pkg::ST_IDLE: begin
        // A fresh enable is seen here first, so the move follows a cycle later
        if (act0 && (m2m0 || req0)) begin
          d.ch = 1'b0;
          d.st = tcdr_pkg::ST_MOVE;
        end else if (act1 && req1) begin
          d.ch = 1'b1;
          d.st = tcdr_pkg::ST_MOVE;
        end
      end
      tcdr_pkg::ST_MOVE: begin
        if (!sel_act) begin
          d.st = tcdr_pkg::ST_IDLE;
        end else if (push) begin
          if (last) begin
            d.st = tcdr_pkg::ST_IDLE;
          end else if (!q.ch && m2m0) begin
            d.st = q.mode[tcdr_pkg::MD_BURST] ? tcdr_pkg::ST_MOVE
                                               : tcdr_pkg::ST_GAP;
          end else begin
            d.st = tcdr_pkg::ST_IDLE;
          end
        end
      end
      tcdr_pkg::ST_GAP: d.st = tcdr_pkg::ST_IDLE;
      default: d.st = tcdr_pkg::ST_IDLE;
    endcase
    if (push) begin
      if (q.ch) begin
        d.ch1_byte_count = q.ch1_byte_count - 16'h0001;
        d.ch1_memory_address = step(q.ch1_memory_address, {1'b0, q.ctl[tcdr_pkg::CT_STEP]});
        d.pend1 = 1'b0;
        if (last) begin
          d.de1 = 1'b0;
        end
      end else begin
        d.ch0_byte_count = q.ch0_byte_count - 16'h0001;
        d.ch0_source_address = step(q.ch0_source_address, sm);
        d.ch0_destination_address = step(q.ch0_destination_address, dm);
        d.pend0 = 1'b0;
        if (last) begin
          d.de0 = 1'b0;
        end
      end
    end
    // Edge sense: a falling edge arriving while the pending flag clears still counts
    if (q.lv0 && !d.lv0) begin
      d.pend0 = 1'b1;
    end
    if (q.lv1 && !d.lv1) begin
      d.pend1 = 1'b1;
    end
    if (io_wr_i) begin
      case (a)
        tcdr_pkg::ADDR_CH0_SOURCE_ADDRESS: d.ch0_source_address[7:0] = w;
        tcdr_pkg::ADDR_CH0_SOURCE_ADDRESS + tcdr_pkg::BYTE1: d.ch0_source_address[15:8] = w;
        tcdr_pkg::ADDR_CH0_SOURCE_ADDRESS + tcdr_pkg::BYTE2: d.ch0_source_address[19:16] = w[3:0];
        tcdr_pkg::ADDR_CH0_DESTINATION_ADDRESS: d.ch0_destination_address[7:0] = w;
        tcdr_pkg::ADDR_CH0_DESTINATION_ADDRESS + tcdr_pkg::BYTE1: d.ch0_destination_address[15:8] = w;
        tcdr_pkg::ADDR_CH0_DESTINATION_ADDRESS + tcdr_pkg::BYTE2: d.ch0_destination_address[19:16] = w[3:0];
        tcdr_pkg::ADDR_CH0_BYTE_COUNT: d.ch0_byte_count[7:0] = w;
        tcdr_pkg::ADDR_CH0_BYTE_COUNT + tcdr_pkg::BYTE1: d.ch0_byte_count[15:8] = w;
        tcdr_pkg::ADDR_CH1_MEMORY_ADDRESS: d.ch1_memory_address[7:0] = w;
        tcdr_pkg::ADDR_CH1_MEMORY_ADDRESS + tcdr_pkg::BYTE1: d.ch1_memory_address[15:8] = w;
        tcdr_pkg::ADDR_CH1_MEMORY_ADDRESS + tcdr_pkg::BYTE2: d.ch1_memory_address[19:16] = w[3:0];
        tcdr_pkg::ADDR_CH1_IO_ADDRESS: d.ch1_io_address[7:0] = w;
        tcdr_pkg::ADDR_CH1_IO_ADDRESS + tcdr_pkg::BYTE1: d.ch1_io_address[15:8] = w;
        tcdr_pkg::ADDR_CH1_BYTE_COUNT: d.ch1_byte_count[7:0] = w;
        tcdr_pkg::ADDR_CH1_BYTE_COUNT + tcdr_pkg::BYTE1: d.ch1_byte_count[15:8] = w;
        tcdr_pkg::ADDR_STAT: begin
          // Main enable has no direct write path
          if (!w[tcdr_pkg::ST_WE0]) begin
            d.de0 = w[tcdr_pkg::ST_DE0];
            d.main_enable = d.main_enable | w[tcdr_pkg::ST_DE0];
          end
          if (!w[tcdr_pkg::ST_WE1]) begin
            d.de1 = w[tcdr_pkg::ST_DE1];
            d.main_enable = d.main_enable | w[tcdr_pkg::ST_DE1];
          end
          d.ie0 = w[tcdr_pkg::ST_IE0];
          d.ie1 = w[tcdr_pkg::ST_IE1];
        end
        tcdr_pkg::ADDR_MODE: d.mode = w & tcdr_pkg::MODE_MASK;
        tcdr_pkg::ADDR_CTL: d.ctl = w;
        default: ;
      endcase
    end
    // Handled last so an NMI beats a same-cycle re-enable; software retries after it
    if (nmi_i) begin
      d.main_enable = 1'b0;
    end
    if (io_rd_i) begin
      case (a)
        tcdr_pkg::ADDR_CH0_SOURCE_ADDRESS: d.rdata = q.ch0_source_address[7:0];
        tcdr_pkg::ADDR_CH0_SOURCE_ADDRESS + tcdr_pkg::BYTE1: d.rdata = q.ch0_source_address[15:8];
        tcdr_pkg::ADDR_CH0_SOURCE_ADDRESS + tcdr_pkg::BYTE2: d.rdata = {4'h0, q.ch0_source_address[19:16]};
        tcdr_pkg::ADDR_CH0_DESTINATION_ADDRESS: d.rdata = q.ch0_destination_address[7:0];
        tcdr_pkg::ADDR_CH0_DESTINATION_ADDRESS + tcdr_pkg::BYTE1: d.rdata = q.ch0_destination_address[15:8];
        tcdr_pkg::ADDR_CH0_DESTINATION_ADDRESS + tcdr_pkg::BYTE2: d.rdata = {4'h0, q.ch0_destination_address[19:16]};
        tcdr_pkg::ADDR_CH0_BYTE_COUNT: d.rdata = q.ch0_byte_count[7:0];
        tcdr_pkg::ADDR_CH0_BYTE_COUNT + tcdr_pkg::BYTE1: d.rdata = q.ch0_byte_count[15:8];
        tcdr_pkg::ADDR_CH1_MEMORY_ADDRESS: d.rdata = q.ch1_memory_address[7:0];
        tcdr_pkg::ADDR_CH1_MEMORY_ADDRESS + tcdr_pkg::BYTE1: d.rdata = q.ch1_memory_address[15:8];
        tcdr_pkg::ADDR_CH1_MEMORY_ADDRESS + tcdr_pkg::BYTE2: d.rdata = {4'h0, q.ch1_memory_address[19:16]};
        tcdr_pkg::ADDR_CH1_IO_ADDRESS: d.rdata = q.ch1_io_address[7:0];
        tcdr_pkg::ADDR_CH1_IO_ADDRESS + tcdr_pkg::BYTE1: d.rdata = q.ch1_io_address[15:8];
        tcdr_pkg::ADDR_CH1_BYTE_COUNT: d.rdata = q.ch1_byte_count[7:0];
        tcdr_pkg::ADDR_CH1_BYTE_COUNT + tcdr_pkg::BYTE1: d.rdata = q.ch1_byte_count[15:8];
        tcdr_pkg::ADDR_STAT: d.rdata = {q.de1, q.de0, 2'b11, q.ie1, q.ie0, 1'b0, q.main_enable};
        tcdr_pkg::ADDR_MODE: d.rdata = q.mode;
        tcdr_pkg::ADDR_CTL: d.rdata = q.ctl;
        default: d.rdata = 8'h00;
      endcase
    end
    d.irq0 = !d.de0 && d.ie0;
    d.irq1 = !d.de1 && d.ie1;
    d.hold = (d.st == tcdr_pkg::ST_MOVE);
    // Output stage keeps every transfer port on a flip-flop
    if (f_valid && f_pop) begin
      d.ov = 1'b1;
      d.od = f_data;
    end else if (xfer_ready_i) begin
      d.ov = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.s0 <= 3'h7;
      q.s1 <= 3'h7;
      q.lv0 <= 1'b1;
      q.lv1 <= 1'b1;
      q.mode <= tcdr_pkg::MODE_RST;
      q.ctl <= tcdr_pkg::CTL_RST;
    end else if (en_i) begin
      q <= d;
    end
  end

  assign io_rdata_o = q.rdata;
  assign xfer_valid_o = q.ov;
  assign {xfer_ch_o, xfer_src_io_o, xfer_dst_io_o, xfer_last_o,
          xfer_src_addr_o, xfer_dst_addr_o} = q.od;
  assign bus_hold_o = q.hold;
  assign ch0_irq_o = q.irq0;
  assign ch1_irq_o = q.irq1;
  assign mem_wait_o = q.ctl[tcdr_pkg::CT_MW_LO +: 2];
  assign io_wait_o = q.ctl[tcdr_pkg::CT_IW_LO +: 2];

  logic stat_wr;
  assign stat_wr = en_i && io_wr_i && (a == tcdr_pkg::ADDR_STAT);

  sequence s_ch0_byte;
    en_i && push && !q.ch && !(io_wr_i && (a[7:1] == tcdr_pkg::ADDR_CH0_BYTE_COUNT[7:1]));
  endsequence
  sequence s_en0_write;
    stat_wr && !w[tcdr_pkg::ST_WE0] && w[tcdr_pkg::ST_DE0] && !nmi_i;
  endsequence

  a_count_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_ch0_byte |=> q.ch0_byte_count == $past(q.ch0_byte_count) - 16'h0001) else $error("count did not step");
  a_term_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_ch0_byte ##0 last && !stat_wr |=> !q.de0 && q.st == tcdr_pkg::ST_IDLE)
    else $error("enable kept after last byte");
  a_move_gated: assert property (@(posedge clk_i) disable iff (!nrst_i)
    push |-> (q.ch ? q.de1 : q.de0) && q.main_enable) else $error("byte moved while disabled");
  a_irq_level: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ch0_irq_o == (!q.de0 && q.ie0) && ch1_irq_o == (!q.de1 && q.ie1))
    else $error("interrupt level wrong");
  a_strobe_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    stat_wr && w[tcdr_pkg::ST_WE0] && !push |=> $stable(q.de0)) else $error("unstrobed write");
  a_strobe_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_i && io_rd_i && a == tcdr_pkg::ADDR_STAT |=> io_rdata_o[5:4] == 2'b11)
    else $error("strobe bits not read as one");
  a_enable_main: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_en0_write |=> q.main_enable && q.de0) else $error("main enable not set");
  a_nmi_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_i && nmi_i |=> !q.main_enable ##1 (!q.main_enable || $past(stat_wr))) else $error("nmi did not clear");
  a_steal_gap: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_ch0_byte ##0 m2m0 && !last && !q.mode[tcdr_pkg::MD_BURST] |=> !push ##1 !push)
    else $error("no processor slot");
  a_start_delay: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_en0_write and (!q.de0 && q.st == tcdr_pkg::ST_IDLE) |=> !push)
    else $error("started early");
endmodule

`default_nettype wire

// ---- include/tcdr_pkg.sv ----
package tcdr_pkg;
  // Register byte addresses in the internal I/O space
  localparam logic [7:0] ADDR_CH0_SOURCE_ADDRESS = 8'h20;
  localparam logic [7:0] ADDR_CH0_DESTINATION_ADDRESS = 8'h23;
  localparam logic [7:0] ADDR_CH0_BYTE_COUNT = 8'h26;
  localparam logic [7:0] ADDR_CH1_MEMORY_ADDRESS = 8'h28;
  localparam logic [7:0] ADDR_CH1_IO_ADDRESS = 8'h2B;
  localparam logic [7:0] ADDR_CH1_BYTE_COUNT = 8'h2E;
  localparam logic [7:0] ADDR_STAT = 8'h30;
  localparam logic [7:0] ADDR_MODE = 8'h31;
  localparam logic [7:0] ADDR_CTL = 8'h32;
  localparam logic [7:0] BYTE1 = 8'h01;
  localparam logic [7:0] BYTE2 = 8'h02;
  // transfer_status_enable fields
  localparam int ST_DE1 = 7;
  localparam int ST_DE0 = 6;
  localparam int ST_WE1 = 5;
  localparam int ST_WE0 = 4;
  localparam int ST_IE1 = 3;
  localparam int ST_IE0 = 2;
  localparam int ST_DME = 0;
  // ch0_transfer_mode fields
  localparam int MD_DST_LO = 4;
  localparam int MD_SRC_LO = 2;
  localparam int MD_BURST = 1;
  localparam logic [7:0] MODE_MASK = 8'h3E;
  localparam logic [7:0] MODE_RST = 8'h00;
  // wait_and_request_control fields
  localparam int CT_MW_LO = 6;
  localparam int CT_IW_LO = 4;
  localparam int CT_SENSE1 = 3;
  localparam int CT_SENSE0 = 2;
  localparam int CT_DIR = 1;
  localparam int CT_STEP = 0;
  localparam logic [7:0] CTL_RST = 8'hF0;
  // Address modifier encodings
  localparam logic [1:0] AM_INC = 2'h0;
  localparam logic [1:0] AM_DEC = 2'h1;
  localparam logic [1:0] AM_FIX = 2'h2;
  localparam logic [1:0] AM_IO = 2'h3;
  localparam int ADDR_W = 20;
  localparam int DESC_W = 44;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01,
    ST_GAP = 2'b11
  } tcdr_state_t;
endpackage

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} tcdr_row_t;
  logic clk_i, nrst_i, io_wr_i, io_rd_i, nmi_i, ch1_req_n, v, rdy, stall, slow, req1, ch0_req_n;
  logic [7:0] io_addr_i, io_wdata_i, rdata, r;
  logic [43:0] desc;
  logic hold, prev_hold, watch;
  int num_errors = 0;
  int total_checks = 0;
  tcdr_row_t rows [8] = '{{8'h30, 8'hFF, 8'h3C}, {8'h31, 8'hF6, 8'h36},
    {8'h32, 8'h0C, 8'h0C}, {8'h20, 8'h12, 8'h12}, {8'h22, 8'hFF, 8'h0F},
    {8'h2F, 8'hAB, 8'hAB}, {8'h40, 8'h55, 8'h00}, {8'h2B, 8'hCD, 8'hCD}};
  logic ch, sio, dio, last;
  logic [19:0] sa, da;
  logic [1:0] mw, iw;
  logic irq0, irq1;
  assign desc = {ch, sio, dio, last, sa, da};
  tcdr_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_rdata_o(rdata),
    .nmi_i(nmi_i), .ch0_request_n_i(ch0_req_n), .ch1_request_n_i(ch1_req_n), .xfer_valid_o(v),
    .xfer_ready_i(rdy), .xfer_ch_o(ch), .xfer_src_io_o(sio), .xfer_dst_io_o(dio),
    .xfer_last_o(last), .xfer_src_addr_o(sa), .xfer_dst_addr_o(da), .bus_hold_o(hold),
    .ch0_irq_o(irq0), .ch1_irq_o(irq1), .mem_wait_o(mw), .io_wait_o(iw));
  tcdr_sink u_sink (.clk_i(clk_i), .nrst_i(nrst_i), .stall_i(stall), .slow_i(slow),
    .req1_i(req1), .valid_i(v), .ready_o(rdy), .desc_i(desc), .ch1_request_n_o(ch1_req_n));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = !clk_i;
  end
  // Cycle steal must hand the bus back between bytes
  always @(posedge clk_i) begin
    prev_hold <= hold;
    if (watch && hold && prev_hold) begin
      fail("bus held two cycles in steal mode");
    end
  end
  task automatic complete_run();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    num_errors++;
    $display("mismatch %0t %s", $time, m);
    complete_run();
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_desc(input int i, input logic [43:0] e);
    total_checks++;
    if (u_sink.log_q[i] !== e) begin
      num_errors++;
      $display("mismatch %0t descriptor %0d %h expected %h", $time, i, u_sink.log_q[i], e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge clk_i);
    io_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge clk_i);
    io_rd_i = 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask
  task automatic set3(input logic [7:0] a, input logic [23:0] x);
    wr(a, x[7:0]);
    wr(a + 8'h01, x[15:8]);
    wr(a + 8'h02, x[23:16]);
  endtask
  task automatic wait_desc(input int n);
    int k;
    k = 0;
    while (u_sink.log_q.size() < n && k < 400) begin
      @(negedge clk_i);
      k++;
    end
    if (u_sink.log_q.size() < n) begin
      fail("descriptor wait ran out");
    end
  endtask
  task automatic reset_checks();
    rd(tcdr_pkg::ADDR_STAT, r);
    chk8(r, 8'h30);
    rd(tcdr_pkg::ADDR_CTL, r);
    chk8(r, 8'hF0);
    rd(tcdr_pkg::ADDR_MODE, r);
    chk8(r, 8'h00);
    chk8({4'h0, mw, iw}, 8'h0F);
    chk8({6'h0, irq1, irq0}, 8'h00);
  endtask
  initial begin
    {io_wr_i, io_rd_i, nmi_i, stall, slow, req1, watch} = '0;
    ch0_req_n = 1'b1;
    io_addr_i = 8'h00;
    io_wdata_i = 8'h00;
    nrst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    reset_checks();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, r);
      chk8(r, rows[i].e);
    end
    chk8({6'h0, irq1, irq0}, 8'h03);
    // Burst across a 64k boundary while the consumer stalls
    stall = 1'b1;
    wr(tcdr_pkg::ADDR_MODE, 8'h02);
    set3(tcdr_pkg::ADDR_CH0_SOURCE_ADDRESS, 24'h0FFFE);
    set3(tcdr_pkg::ADDR_CH0_DESTINATION_ADDRESS, 24'h00200);
    wr(tcdr_pkg::ADDR_CH0_BYTE_COUNT, 8'h06);
    wr(tcdr_pkg::ADDR_CH0_BYTE_COUNT + 8'h01, 8'h00);
    u_sink.log_q.delete();
    wr(tcdr_pkg::ADDR_STAT, 8'h64);
    repeat (20) @(negedge clk_i);
    chk8(8'(u_sink.log_q.size()), 8'h00);
    stall = 1'b0;
    wait_desc(6);
    for (int i = 0; i < 6; i++) begin
      chk_desc(i, {3'b000, i == 5, 20'h0FFFE + 20'(i), 20'h00200 + 20'(i)});
    end
    rd(tcdr_pkg::ADDR_STAT, r);
    chk8(r, 8'h35);
    rd(tcdr_pkg::ADDR_CH0_BYTE_COUNT, r);
    chk8(r, 8'h00);
    chk8({6'h0, irq1, irq0}, 8'h01);
    // Cycle steal, source decrement, fixed destination, slow consumer
    slow = 1'b1;
    wr(tcdr_pkg::ADDR_MODE, 8'h24);
    set3(tcdr_pkg::ADDR_CH0_SOURCE_ADDRESS, 24'h00010);
    set3(tcdr_pkg::ADDR_CH0_DESTINATION_ADDRESS, 24'h00050);
    wr(tcdr_pkg::ADDR_CH0_BYTE_COUNT, 8'h03);
    u_sink.log_q.delete();
    watch = 1'b1;
    wr(tcdr_pkg::ADDR_STAT, 8'h64);
    wait_desc(3);
    watch = 1'b0;
    slow = 1'b0;
    for (int i = 0; i < 3; i++) begin
      chk_desc(i, {3'b000, i == 2, 20'h00010 - 20'(i), 20'h00050});
    end
    // Non-maskable interrupt stops the engine until it drops and a channel is rewritten
    @(negedge clk_i);
    nmi_i = 1'b1;
    @(negedge clk_i);
    rd(tcdr_pkg::ADDR_STAT, r);
    chk8(r, 8'h34);
    wr(tcdr_pkg::ADDR_MODE, 8'h02);
    wr(tcdr_pkg::ADDR_CH0_BYTE_COUNT, 8'h02);
    u_sink.log_q.delete();
    wr(tcdr_pkg::ADDR_STAT, 8'h64);
    repeat (20) @(negedge clk_i);
    chk8(8'(u_sink.log_q.size()), 8'h00);
    rd(tcdr_pkg::ADDR_STAT, r);
    chk8(r, 8'h74);
    nmi_i = 1'b0;
    wr(tcdr_pkg::ADDR_STAT, 8'h64);
    wait_desc(2);
    chk8(8'(u_sink.log_q.size()), 8'h02);
    // Channel 1, I/O to memory with decrement, paced by a level request
    wr(tcdr_pkg::ADDR_CTL, 8'hF3);
    set3(tcdr_pkg::ADDR_CH1_MEMORY_ADDRESS, 24'h00300);
    wr(tcdr_pkg::ADDR_CH1_IO_ADDRESS, 8'h44);
    wr(tcdr_pkg::ADDR_CH1_IO_ADDRESS + 8'h01, 8'h00);
    wr(tcdr_pkg::ADDR_CH1_BYTE_COUNT, 8'h02);
    wr(tcdr_pkg::ADDR_CH1_BYTE_COUNT + 8'h01, 8'h00);
    u_sink.log_q.delete();
    wr(tcdr_pkg::ADDR_STAT, 8'h9C);
    repeat (10) @(negedge clk_i);
    chk8(8'(u_sink.log_q.size()), 8'h00);
    req1 = 1'b1;
    wait_desc(2);
    req1 = 1'b0;
    for (int i = 0; i < 2; i++) begin
      chk_desc(i, {3'b110, i == 1, 20'h00044, 20'h00300 - 20'(i)});
    end
    rd(tcdr_pkg::ADDR_STAT, r);
    chk8(r, 8'h3D);
    chk8({6'h0, irq1, irq0}, 8'h03);
    // Channel 0 memory to I/O: one byte per synced falling edge, burst bit ignored
    wr(tcdr_pkg::ADDR_CTL, 8'hF4);
    wr(tcdr_pkg::ADDR_MODE, 8'h32);
    set3(tcdr_pkg::ADDR_CH0_SOURCE_ADDRESS, 24'h00080);
    set3(tcdr_pkg::ADDR_CH0_DESTINATION_ADDRESS, 24'h00012);
    wr(tcdr_pkg::ADDR_CH0_BYTE_COUNT, 8'h02);
    u_sink.log_q.delete();
    wr(tcdr_pkg::ADDR_STAT, 8'h64);
    repeat (10) @(negedge clk_i);
    chk8(8'(u_sink.log_q.size()), 8'h00);
    for (int p = 1; p <= 2; p++) begin
      ch0_req_n = 1'b0;
      repeat (6) @(negedge clk_i);
      ch0_req_n = 1'b1;
      repeat (8) @(negedge clk_i);
      chk8(8'(u_sink.log_q.size()), 8'(p));
    end
    for (int i = 0; i < 2; i++) begin
      chk_desc(i, {3'b001, i == 1, 20'h00080 + 20'(i), 20'h00012});
    end
    rd(tcdr_pkg::ADDR_STAT, r);
    chk8(r, 8'h35);
    // Second reset in mid-run
    nrst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    reset_checks();
    complete_run();
  end
endmodule
`default_nettype wire

// ---- tb/tcdr_sink.sv ----
`timescale 1ns/1ns
`default_nettype none
module tcdr_sink (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic stall_i,
  input wire logic slow_i,
  input wire logic req1_i,
  input wire logic valid_i,
  output logic ready_o,
  input wire logic [43:0] desc_i,
  output logic ch1_request_n_o
);
  logic [43:0] log_q[$];
  logic tick_q;
  // Peripheral holds its request low until it is told to stop
  assign ch1_request_n_o = !req1_i;
  // Slow mode accepts every other cycle so the fifo sees back pressure
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_o <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      if (valid_i && ready_o) begin
        log_q.push_back(desc_i);
      end
      tick_q <= !tick_q;
      ready_o <= !stall_i && (!slow_i || tick_q);
    end
  end
endmodule
`default_nettype wire
